// file: design/i2c_sw_map.vh
// Register offsets, limits and reset values for the switch register access
`ifndef I2C_SW_MAP_VH
`define I2C_SW_MAP_VH

// ==================================================================
// Register offsets
`define OFS_CHAN_SEL     3'h0
`define OFS_CONFIG       3'h1
`define OFS_FLUSH_SEQ    3'h2
`define OFS_RD_FIRST     3'h3
`define OFS_RD_LAST      3'h6

// ==================================================================
// Pointer limits
`define PTR_WR_LAST      3'h2
`define PTR_RD_LAST      3'h6

// ==================================================================
// Reset values
`define RST_CHAN_SEL     8'h00
`define RST_CONFIG       8'h00
`define RST_FLUSH_SEQ    8'h00

// ==================================================================
// Bit handling
`define BIT_LAST         3'h7
`define RW_BIT_POS       0

`endif

// file: design/line_watch.v
// Edge, START and STOP detection on the two-wire bus lines
`timescale 1ns/1ps
module line_watch
(
   input  wire clk,
   input  wire rst_n,
   input  wire scl_in,
   input  wire sda_in,
   output wire scl_rise,
   output wire scl_fall,
   output wire start_det,
   output wire stop_det,
   output wire sda_now
);

   reg scl_q_r;   // Sampled clock line
   reg sda_q_r;   // Sampled data line
   reg scl_p_r;   // Clock line one cycle earlier
   reg sda_p_r;   // Data line one cycle earlier

   // ==================================================================
   // Line sampling, idle lines read high
   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         scl_q_r <= 1'b1;
         sda_q_r <= 1'b1;
         scl_p_r <= 1'b1;
         sda_p_r <= 1'b1;
      end
      else
      begin
         scl_q_r <= scl_in;
         sda_q_r <= sda_in;
         scl_p_r <= scl_q_r;
         sda_p_r <= sda_q_r;
      end
   end

   // ==================================================================
   // Events: data moving while the clock stays high frames a transfer
   assign scl_rise  = scl_q_r & ~scl_p_r;
   assign scl_fall  = ~scl_q_r & scl_p_r;
   assign start_det = scl_q_r & scl_p_r & sda_p_r & ~sda_q_r;
   assign stop_det  = scl_q_r & scl_p_r & ~sda_p_r & sda_q_r;
   assign sda_now   = sda_q_r;

endmodule // line_watch

// file: design/reg_bank.v
// Writable control registers and the read multiplexer
`timescale 1ns/1ps
`include "i2c_sw_map.vh"
module reg_bank
#(
   parameter DW = 8
)
(
   input  wire            clk,
   input  wire            rst_n,
   input  wire            wr_en,
   input  wire [2:0]      wr_idx,
   input  wire [DW-1:0]   wr_data,
   input  wire [2:0]      rd_idx,
   input  wire [4*DW-1:0] ro_data,
   output reg  [DW-1:0]   rd_data,
   output reg  [DW-1:0]   chan_sel,
   output reg  [DW-1:0]   config_val,
   output reg  [DW-1:0]   flush_seq
);

   // ==================================================================
   // Writable registers, updated on a write strobe
   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         chan_sel   <= `RST_CHAN_SEL;
         config_val <= `RST_CONFIG;
         flush_seq  <= `RST_FLUSH_SEQ;
      end
      else if (wr_en)
      begin
         case (wr_idx)
            `OFS_CHAN_SEL:  chan_sel   <= wr_data;
            `OFS_CONFIG:    config_val <= wr_data;
            `OFS_FLUSH_SEQ: flush_seq  <= wr_data;
            default:        chan_sel   <= chan_sel;
         endcase
      end
   end

   // ==================================================================
   // Read selection, indices 3 to 6 come from read-only status inputs, index 7 returns channel select
   always @*
   begin
      case (rd_idx)
         `OFS_CHAN_SEL:  rd_data = chan_sel;
         `OFS_CONFIG:    rd_data = config_val;
         `OFS_FLUSH_SEQ: rd_data = flush_seq;
         3'h3:           rd_data = ro_data[DW-1:0];
         3'h4:           rd_data = ro_data[2*DW-1:DW];
         3'h5:           rd_data = ro_data[3*DW-1:2*DW];
         3'h6:           rd_data = ro_data[4*DW-1:3*DW];
         default:        rd_data = chan_sel;
      endcase
   end

endmodule // reg_bank

// file: design/i2c_sw_access.v
// Slave-side two-wire register access for an eight-channel bus switch
//
// Contract
// [RL1] Pointer resets to zero every transaction
// [RL2] Enhanced reads cycle seven registers, wrapping
// [RL3] Enhanced single read returns channel select
// [RL4] Enhanced reads start at zero, then increment
// [RL5] Basic mode exposes channel select only
// [RL6] Basic writes all hit channel select
// [RL7] Basic multibyte read repeats channel select
// [RL8] Write address with low direction is acknowledged
// [RL9] STOP right after address changes nothing
// [RL10] Enhanced writes start at zero, then increment
// [RL11] Enhanced writes acknowledged and applied per byte
// [RL12] Basic writes applied only at STOP
// [RL13] Read address with high direction is acknowledged
// [RL14] Master acknowledges each byte to continue
// [RL15] Basic reads always return channel select
// [RL16] Enhanced writes wrap after third register
// [RL17] Master not-acknowledge releases data, awaits framing
`timescale 1ns/1ps
`include "i2c_sw_map.vh"
module i2c_sw_access
#(
   parameter DW = 8
)
(
   input  wire            clk,
   input  wire            rst_n,
   input  wire            scl_in,
   input  wire            sda_in,
   output reg             sda_out,
   output reg             sda_oe,
   input  wire [6:0]      slave_addr,
   input  wire            enhanced_mode,
   input  wire [4*DW-1:0] status_in,
   output wire [DW-1:0]   chan_sel,
   output wire [DW-1:0]   config_val,
   output wire [DW-1:0]   flush_seq,
   output reg             busy
);

   // ==================================================================
   // State codes
   localparam [3:0] ST_IDLE   = 4'h0;  // Not addressed
   localparam [3:0] ST_ADDR   = 4'h1;  // Receiving address byte
   localparam [3:0] ST_A_ACK  = 4'h2;  // Address matched, ack pending
   localparam [3:0] ST_A_HOLD = 4'h3;  // Driving address ack
   localparam [3:0] ST_WR     = 4'h4;  // Receiving data byte
   localparam [3:0] ST_W_ACK  = 4'h5;  // Data ack pending
   localparam [3:0] ST_W_HOLD = 4'h6;  // Driving data ack
   localparam [3:0] ST_RD     = 4'h7;  // Sending data byte
   localparam [3:0] ST_R_REL  = 4'h8;  // Last bit out, release pending
   localparam [3:0] ST_R_ACK  = 4'h9;  // Sampling master ack
   localparam [3:0] ST_R_LOAD = 4'ha;  // Load next byte on clock fall

   // ==================================================================
   // Declarations
   wire            scl_rise;   // Clock line rising
   wire            scl_fall;   // Clock line falling
   wire            start_det;  // START or repeated START
   wire            stop_det;   // STOP
   wire            sda_now;    // Sampled data line
   wire [DW-1:0]   rd_data;    // Register selected by pointer

   reg  [3:0]      state_r;    // Transfer state
   reg  [3:0]      state_nxt;
   reg  [2:0]      bit_cnt_r;  // Bit within byte
   reg  [2:0]      bit_cnt_nxt;
   reg  [DW-1:0]   shift_r;    // Byte shift register
   reg  [DW-1:0]   shift_nxt;
   reg  [2:0]      ptr_r;      // Register pointer
   reg  [2:0]      ptr_nxt;
   reg             rw_r;       // Direction of current transfer
   reg             rw_nxt;
   reg  [DW-1:0]   pend_r;     // Basic-mode byte held to STOP
   reg  [DW-1:0]   pend_nxt;
   reg             pend_v_r;   // Held byte is valid
   reg             pend_v_nxt;
   reg             oe_nxt;     // Next data line drive
   reg             wr_en;      // Register write strobe
   reg  [2:0]      wr_idx;     // Register write index
   reg  [DW-1:0]   wr_data;    // Register write data
   wire [DW-1:0]   byte_in;    // Completed received byte

   assign byte_in = {shift_r[DW-2:0], sda_now};

   // ==================================================================
   // Line event detection
   line_watch u_watch
   (
      .clk       (clk),
      .rst_n     (rst_n),
      .scl_in    (scl_in),
      .sda_in    (sda_in),
      .scl_rise  (scl_rise),
      .scl_fall  (scl_fall),
      .start_det (start_det),
      .stop_det  (stop_det),
      .sda_now   (sda_now)
   );

   // ==================================================================
   // Register storage
   reg_bank #(.DW(DW)) u_bank
   (
      .clk        (clk),
      .rst_n      (rst_n),
      .wr_en      (wr_en),
      .wr_idx     (wr_idx),
      .wr_data    (wr_data),
      .rd_idx     (ptr_r),
      .ro_data    (status_in),
      .rd_data    (rd_data),
      .chan_sel   (chan_sel),
      .config_val (config_val),
      .flush_seq  (flush_seq)
   );

   // ==================================================================
   // Next-state logic for the transfer engine
   always @*
   begin
      state_nxt   = state_r;
      bit_cnt_nxt = bit_cnt_r;
      shift_nxt   = shift_r;
      ptr_nxt     = ptr_r;
      rw_nxt      = rw_r;
      pend_nxt    = pend_r;
      pend_v_nxt  = pend_v_r;
      oe_nxt      = sda_oe;
      wr_en       = 1'b0;
      wr_idx      = `OFS_CHAN_SEL;
      wr_data     = pend_r;
      if (stop_det)
      begin
         // Release bus; basic mode commits the last byte now
         // [RL12] commit at STOP
         if (pend_v_r)
         begin
            wr_en      = 1'b1;
            wr_idx     = `OFS_CHAN_SEL;
            wr_data    = pend_r;
            pend_v_nxt = 1'b0;
         end
         // [RL9] empty write is harmless
         state_nxt = ST_IDLE;
         oe_nxt    = 1'b0;
      end
      else if (start_det)
      begin
         // [RL1] pointer back to zero
         ptr_nxt     = `OFS_CHAN_SEL;
         bit_cnt_nxt = 3'h0;
         state_nxt   = ST_ADDR;
         oe_nxt      = 1'b0;
      end
      else
      begin
         case (state_r)
            ST_ADDR:
            begin
               // Collect address and direction bit
               if (scl_rise)
               begin
                  shift_nxt   = byte_in;
                  bit_cnt_nxt = bit_cnt_r + 3'h1;
                  if (bit_cnt_r == `BIT_LAST)
                  begin
                     // [RL8] acknowledge own write address
                     // [RL13] acknowledge own read address
                     if (byte_in[7:1] == slave_addr)
                     begin
                        rw_nxt    = byte_in[`RW_BIT_POS];
                        state_nxt = ST_A_ACK;
                     end
                     else
                        state_nxt = ST_IDLE;
                  end
               end
            end
            ST_A_ACK:
            begin
               // Pull data low for the ack bit
               if (scl_fall)
               begin
                  oe_nxt    = 1'b1;
                  state_nxt = ST_A_HOLD;
               end
            end
            ST_A_HOLD:
            begin
               // End of ack: start sending or receiving
               if (scl_fall)
               begin
                  bit_cnt_nxt = 3'h0;
                  if (rw_r)
                  begin
                     // [RL3] first byte is channel select
                     shift_nxt = rd_data;
                     oe_nxt    = ~rd_data[DW-1];
                     state_nxt = ST_RD;
                  end
                  else
                  begin
                     oe_nxt    = 1'b0;
                     state_nxt = ST_WR;
                  end
               end
            end
            ST_WR:
            begin
               // Collect a data byte
               if (scl_rise)
               begin
                  shift_nxt   = byte_in;
                  bit_cnt_nxt = bit_cnt_r + 3'h1;
                  if (bit_cnt_r == `BIT_LAST)
                  begin
                     state_nxt = ST_W_ACK;
                     if (enhanced_mode)
                     begin
                        // [RL11] apply each byte at once
                        // [RL10] write at pointer
                        wr_en   = 1'b1;
                        wr_idx  = ptr_r;
                        wr_data = byte_in;
                        // [RL16] wrap after third register
                        if (ptr_r >= `PTR_WR_LAST)
                           ptr_nxt = `OFS_CHAN_SEL;
                        else
                           ptr_nxt = ptr_r + 3'h1;
                     end
                     else
                     begin
                        // [RL6] keep only the latest byte
                        pend_nxt   = byte_in;
                        pend_v_nxt = 1'b1;
                     end
                  end
               end
            end
            ST_W_ACK:
            begin
               // Acknowledge every data byte
               if (scl_fall)
               begin
                  oe_nxt    = 1'b1;
                  state_nxt = ST_W_HOLD;
               end
            end
            ST_W_HOLD:
            begin
               // Release after ack, next byte follows
               if (scl_fall)
               begin
                  oe_nxt      = 1'b0;
                  bit_cnt_nxt = 3'h0;
                  state_nxt   = ST_WR;
               end
            end
            ST_RD:
            begin
               // Count bits on rise, present next bit on fall
               if (scl_rise)
               begin
                  bit_cnt_nxt = bit_cnt_r + 3'h1;
                  if (bit_cnt_r == `BIT_LAST)
                     state_nxt = ST_R_REL;
               end
               else if (scl_fall)
               begin
                  shift_nxt = {shift_r[DW-2:0], 1'b0};
                  oe_nxt    = ~shift_r[DW-2];
               end
            end
            ST_R_REL:
            begin
               // Free the line for the master's ack bit
               if (scl_fall)
               begin
                  oe_nxt    = 1'b0;
                  state_nxt = ST_R_ACK;
               end
            end
            ST_R_ACK:
            begin
               if (scl_rise)
               begin
                  // [RL14] continue only on master ack
                  if (!sda_now)
                  begin
                     state_nxt = ST_R_LOAD;
                     // [RL5] basic mode pointer forced back to channel select
                     // [RL2] wrap after last register
                     if (!enhanced_mode)
                        ptr_nxt = `OFS_CHAN_SEL;
                     else if (ptr_r >= `PTR_RD_LAST)
                        ptr_nxt = `OFS_CHAN_SEL;
                     else
                        ptr_nxt = ptr_r + 3'h1;
                  end
                  else
                     // [RL17] idle until STOP or START
                     state_nxt = ST_IDLE;
               end
            end
            ST_R_LOAD:
            begin
               // [RL4] next register in order
               // [RL7] basic reads repeat channel select
               // [RL15] basic reads always channel select
               if (scl_fall)
               begin
                  shift_nxt   = rd_data;
                  oe_nxt      = ~rd_data[DW-1];
                  bit_cnt_nxt = 3'h0;
                  state_nxt   = ST_RD;
               end
            end
            default:
            begin
               // Idle: stay off the data line
               oe_nxt    = 1'b0;
               state_nxt = ST_IDLE;
            end
         endcase
      end
   end

   // ==================================================================
   // State and output flip-flops
   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_r   <= ST_IDLE;
         bit_cnt_r <= 3'h0;
         shift_r   <= {DW{1'b0}};
         ptr_r     <= `OFS_CHAN_SEL;
         rw_r      <= 1'b0;
         pend_r    <= {DW{1'b0}};
         pend_v_r  <= 1'b0;
         sda_oe    <= 1'b0;
         sda_out   <= 1'b0;
         busy      <= 1'b0;
      end
      else
      begin
         state_r   <= state_nxt;
         bit_cnt_r <= bit_cnt_nxt;
         shift_r   <= shift_nxt;
         ptr_r     <= ptr_nxt;
         rw_r      <= rw_nxt;
         pend_r    <= pend_nxt;
         pend_v_r  <= pend_v_nxt;
         sda_oe    <= oe_nxt;
         sda_out   <= 1'b0;
         busy      <= (state_nxt != ST_IDLE);
      end
   end

endmodule // i2c_sw_access

// file: verif/sw_access_assertions.sv
// Port checker for the switch register access block
`timescale 1ns/1ps
module sw_access_chk
#(
   parameter DW = 8
)
(
   input wire          clk,
   input wire          rst_n,
   input wire          scl_in,
   input wire          sda_in,
   input wire          sda_out,
   input wire          sda_oe,
   input wire          enhanced_mode,
   input wire [DW-1:0] chan_sel,
   input wire [DW-1:0] config_val,
   input wire [DW-1:0] flush_seq,
   input wire          busy
);
   // ==========================================
   // STOP tracking
   reg       sda_r;   // Last data line sample
   reg [3:0] gap_r;   // Cycles since a STOP, saturating
   wire      stop_now = scl_in && sda_in && !sda_r;
   // Age of the most recent STOP on the pins
   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         sda_r <= 1'b1;
         gap_r <= 4'hf;
      end
      else
      begin
         sda_r <= sda_in;
         gap_r <= stop_now ? 4'h0 : gap_r + {3'h0, gap_r != 4'hf};
      end
   end
   // ==========================================
   // Assertions
   default clocking dc @(posedge clk);
   endclocking
   default disable iff (!rst_n);
   a_drive_low_only: assert property (!sda_out)
      else $error("data output not held low");
   a_change_scl_low: assert property ($changed(sda_oe) |-> !scl_in)
      else $error("data line moved while clock high");
   a_idle_released: assert property (!busy |-> !sda_oe)
      else $error("data line driven while idle");
   a_basic_regs_hold: assert property
      (!enhanced_mode |-> $stable(config_val) && $stable(flush_seq))
      else $error("hidden register changed in basic mode");
   a_basic_at_stop: assert property
      (!enhanced_mode && $changed(chan_sel) |-> gap_r < 4'h6)
      else $error("basic write applied away from STOP");
   a_enh_chan_busy: assert property
      (enhanced_mode && $changed(chan_sel) |-> busy)
      else $error("enhanced write not applied per byte");
   a_enh_cfg_busy: assert property
      ($changed(config_val) |-> busy && enhanced_mode)
      else $error("config changed outside enhanced write");
   a_stop_idle: assert property (stop_now |-> ##[1:6] !busy)
      else $error("engine not idle after STOP");
endmodule // sw_access_chk

bind i2c_sw_access sw_access_chk #(.DW(DW)) u_chk
(
   .clk(clk), .rst_n(rst_n), .scl_in(scl_in), .sda_in(sda_in),
   .sda_out(sda_out), .sda_oe(sda_oe), .enhanced_mode(enhanced_mode),
   .chan_sel(chan_sel), .config_val(config_val),
   .flush_seq(flush_seq), .busy(busy)
);

// file: verif/i2c_host_model.sv
// Bus master model on the host side of the two-wire link
`timescale 1ns/1ps
module i2c_host_model
(
   input  wire       clk,
   input  wire       sda,      // Resolved data line
   output reg        scl,      // Clock line, driven push-pull
   output reg        sda_pull, // High while pulling data low
   output reg  [7:0] rd_byte,  // Last byte read
   output reg        rd_vld    // One-cycle pulse per byte read
);
   // Idle bus at time zero
   initial
   begin
      scl = 1'b1;
      sda_pull = 1'b0;
      rd_byte = 8'h00;
      rd_vld = 1'b0;
   end
   task hold(input integer n);
      repeat (n) @(posedge clk);
   endtask
   // One bit: data moves in low phase, sampled at end of high phase
   task bit_io(input b, output r);
   begin
      hold(2);
      sda_pull <= !b;
      hold(4);
      scl <= 1'b1;
      hold(4);
      r = sda;
      scl <= 1'b0;
   end
   endtask
   // START, or repeated START from a low clock
   task start;
   begin
      hold(2);
      sda_pull <= 1'b0;
      hold(4);
      scl <= 1'b1;
      hold(4);
      sda_pull <= 1'b1;
      hold(4);
      scl <= 1'b0;
   end
   endtask
   // STOP, then bus left free
   task stop;
   begin
      hold(2);
      sda_pull <= 1'b1;
      hold(4);
      scl <= 1'b1;
      hold(4);
      sda_pull <= 1'b0;
      hold(4);
   end
   endtask
   // byte sent MSB first, acknowledge sampled
   task wbyte(input [7:0] b, output ack);
      integer i;
      reg     r;
   begin
      for (i = 7; i >= 0; i = i - 1)
         bit_io(b[i], r);
      bit_io(1'b1, r);
      ack = !r;
   end
   endtask
   // master acknowledges every byte but the last
   task rbyte(input more, output [7:0] d);
      integer i;
      reg     r;
   begin
      for (i = 7; i >= 0; i = i - 1)
      begin
         bit_io(1'b1, r);
         d[i] = r;
      end
      bit_io(!more, r);
      rd_byte <= d;
      rd_vld <= 1'b1;
      hold(1);
      rd_vld <= 1'b0;
   end
   endtask
endmodule // i2c_host_model

// file: verif/i2c_sw_access_tb_top.sv
// Self-checking bench for the switch register access block
`timescale 1ns/1ps
module i2c_sw_access_tb_top;
   reg         clk, rst_n, enhanced_mode;
   reg  [6:0]  slave_addr;
   reg  [31:0] status_in;
   wire        scl, sda, sda_out, sda_oe, sda_pull, rd_vld, busy;
   wire [7:0]  chan_sel, config_val, flush_seq, rd_byte;
   integer     err_total, check_count, seed;
   reg  [7:0]  r0, r1, r2;  // Expected writable registers
   reg  [7:0]  wq [0:7];    // Bytes to write
   reg  [7:0]  exp_q [$];   // Expected read bytes, oldest first
   // Open-drain data line with pull-up
   assign sda = !(sda_pull | sda_oe);
   always #12.5 clk = ~clk;
   i2c_sw_access #(.DW(8)) u_dut
   (
      .clk(clk), .rst_n(rst_n), .scl_in(scl), .sda_in(sda),
      .sda_out(sda_out), .sda_oe(sda_oe), .slave_addr(slave_addr),
      .enhanced_mode(enhanced_mode), .status_in(status_in),
      .chan_sel(chan_sel), .config_val(config_val),
      .flush_seq(flush_seq), .busy(busy)
   );
   i2c_host_model u_host
   (
      .clk(clk), .sda(sda), .scl(scl), .sda_pull(sda_pull),
      .rd_byte(rd_byte), .rd_vld(rd_vld)
   );
   task chk(input [7:0] got, input [7:0] exp);
   begin
      check_count = check_count + 1;
      if (got !== exp)
      begin
         err_total = err_total + 1;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   end
   endtask
   task stop_test;
   begin
      if (err_total == 0 && check_count > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   end
   endtask
   // Each byte read is matched against the oldest note
   always @(posedge clk)
      if (rd_vld === 1'b1)
         chk(rd_byte, exp_q.pop_front());
   task regs_chk;
   begin
      chk(chan_sel, r0);
      chk(config_val, r1);
      chk(flush_seq, r2);
   end
   endtask
   task fill;
      integer i;
   begin
      for (i = 0; i < 8; i = i + 1)
         wq[i] = 8'($random(seed));
   end
   endtask
   // One transaction: address, n bytes, optional STOP
   task tx(input [6:0] a, input rd, input integer n, input fin);
      reg        ak;
      reg  [7:0] d;
      integer    i;
   begin
      u_host.start();
      u_host.wbyte({a, rd}, ak);
      chk({7'h00, ak}, {7'h00, a == slave_addr});
      for (i = 0; i < n && ak; i = i + 1)
         if (rd)
            u_host.rbyte(i < n - 1, d);
         else
         begin
            u_host.wbyte(wq[i], ak);
            chk({7'h00, ak}, 8'h01);
         end
      if (rd && ak)
      begin
         u_host.hold(4);
         chk({7'h00, sda}, 8'h01);
      end
      if (fin)
         u_host.stop();
   end
   endtask
   // Watchdog against a hung transfer
   initial
   begin
      repeat (60000) @(posedge clk);
      err_total = err_total + 1;
      stop_test;
   end
   // ==========================================
   // Main sequence
   initial
   begin
      clk = 1'b0;
      rst_n = 1'b0;
      err_total = 0;
      check_count = 0;
      seed = 71767;
      slave_addr = 7'($random(seed));
      status_in = $random(seed);
      enhanced_mode = 1'b1;
      r0 = 8'h00;
      r1 = 8'h00;
      r2 = 8'h00;
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      repeat (2) @(posedge clk);
      regs_chk;
      // Five bytes wrap over the three writable registers
      fill;
      tx(slave_addr, 1'b0, 5, 1'b1);
      r0 = wq[3];
      r1 = wq[4];
      r2 = wq[2];
      regs_chk;
      // Nine reads wrap after seven registers
      exp_q = {r0, r1, r2, status_in[7:0], status_in[15:8],
               status_in[23:16], status_in[31:24], r0, r1};
      tx(slave_addr, 1'b1, 9, 1'b1);
      exp_q.push_back(r0);
      tx(slave_addr, 1'b1, 1, 1'b1);
      tx(slave_addr, 1'b0, 0, 1'b1);
      regs_chk;
      // Repeated START restarts the pointer at zero
      fill;
      tx(slave_addr, 1'b0, 1, 1'b0);
      r0 = wq[0];
      exp_q = {r0, r1};
      tx(slave_addr, 1'b1, 2, 1'b1);
      tx(slave_addr ^ 7'h01, 1'b0, 1, 1'b1);
      regs_chk;
      // Basic mode: writes pend until STOP, last byte wins
      enhanced_mode <= 1'b0;
      fill;
      tx(slave_addr, 1'b0, 4, 1'b0);
      regs_chk;
      u_host.stop();
      r0 = wq[3];
      regs_chk;
      exp_q = {r0, r0, r0};
      tx(slave_addr, 1'b1, 3, 1'b1);
      chk(8'(exp_q.size()), 8'h00);
      stop_test;
   end
endmodule // i2c_sw_access_tb_top
